// File: rtl/isr_pkg.sv
// Shared constants and carrier types for the status reporting core
package isr_pkg;
    // ------------------------------------------------------------
    // Summary byte bit positions
    // ------------------------------------------------------------
    localparam int SB_QUEUE_BIT = 2;
    localparam int SB_DOUBT_BIT = 3;
    localparam int SB_MSG_BIT   = 4;
    localparam int SB_STD_BIT   = 5;
    localparam int SB_RQS_BIT   = 6;
    localparam int SB_RUN_BIT   = 7;
    // ------------------------------------------------------------
    // Standard event bit positions
    // ------------------------------------------------------------
    localparam int SE_ALL_DONE  = 0;
    localparam int SE_QUERY     = 2;
    localparam int SE_DEVICE    = 3;
    localparam int SE_RUN       = 4;
    localparam int SE_PARSE     = 5;
    localparam int SE_LOCAL_KEY = 6;
    localparam int SE_POWER_UP  = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  STD_EVENT_RESET = 8'h80;
    localparam logic [7:0]  MASK8_RESET     = 8'h00;
    localparam logic [15:0] MASK16_RESET    = 16'h0000;
    // ------------------------------------------------------------
    // Error codes (signed, 16 bit)
    // ------------------------------------------------------------
    localparam logic signed [15:0] ERR_NONE       = 16'sh0000;
    localparam logic signed [15:0] ERR_PARSE      = -16'sd100;
    localparam logic signed [15:0] ERR_RUN_LO     = -16'sd222;
    localparam logic signed [15:0] ERR_RUN_HI     = -16'sd200;
    localparam logic signed [15:0] ERR_DEV_LO     = -16'sd350;
    localparam logic signed [15:0] ERR_DEV_HI     = -16'sd240;
    localparam logic signed [15:0] ERR_QRY_LO     = -16'sd430;
    localparam logic signed [15:0] ERR_QRY_HI     = -16'sd410;
    localparam logic signed [15:0] ERR_OVERFLOW   = -16'sd350;

    // Host-facing command set
    typedef enum logic [3:0] {
        ISR_CMD_NONE,
        ISR_CMD_STB_READ,
        ISR_CMD_ESR_READ,
        ISR_CMD_ESE_WRITE,
        ISR_CMD_ESE_READ,
        ISR_CMD_SRE_WRITE,
        ISR_CMD_SRE_READ,
        ISR_CMD_QEN_WRITE,
        ISR_CMD_QEN_READ,
        ISR_CMD_OEN_WRITE,
        ISR_CMD_OEN_READ,
        ISR_CMD_ERR_READ,
        ISR_CMD_CLS
    } isr_cmd_e_t;

    typedef struct packed {
        isr_cmd_e_t  cmd;
        logic [15:0] wdata;
    } isr_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } isr_rsp_t;

    // Event pulses from the instrument
    typedef struct packed {
        logic all_done;
        logic local_key_event;
        logic device_fault;
        logic run_fault;
        logic parse_fault;
        logic query_protocol_fault;
    } isr_evt_t;
endpackage

// File: rtl/isr_status.sv
// Status byte, standard event register, masks and error queue
// ------------------------------------------------------------
// Status reporting core
// ------------------------------------------------------------
// Overview of operation
// - Summary bits 0 and 1 always zero
// - Bit 2 set while error queue nonempty
// - Bit 3 is masked doubtful summary
// - Bit 4 set while output queue holds reply
// - Bit 5 is masked standard event summary
// - Bit 6 is service request flag
// - Bit 7 (run state summary) always zero
// - Poll and query return same summary byte
// - Event bit 0 on all done; bit 1 zero
// - Event bit 2 on query protocol fault
// - Bits 3,4,5 device, run, parse faults
// - Event bit 6 on local key press
// - Event bit 7 marks power up
// - Event query returns then clears register
// - Summary is OR of status AND enable
// - Event mask written and read back
// - Run state enable writable, never reports
// - Doubtful enable set and read, summarised
// - Service mask gates service request
// - New message clears the output queue
// - FIFO error queue, overflow logs -350, blocks
// - Error codes map to event bits
// - Doubtful events latch rising edges; clear status clears
module isr_status #(
    parameter int QDEPTH = 8
) (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire isr_pkg::isr_req_t     req,
    output isr_pkg::isr_rsp_t          rsp,
    input  wire isr_pkg::isr_evt_t     evt,
    input  wire logic                  err_push,
    input  wire logic signed [15:0]    err_code,
    input  wire logic [15:0]           doubtful_cond,
    input  wire logic                  msg_put,
    input  wire logic                  msg_take,
    input  wire logic                  new_message,
    output logic [7:0]                 summary_byte,
    output logic                       service_request_flag
);
    localparam int PW = $clog2(QDEPTH);

    // Pointer wrap arithmetic only works for power-of-two depths
    if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("QDEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  std_event_reg_q;
    logic [7:0]  std_event_mask_q;
    logic [7:0]  service_mask_q;
    logic [15:0] doubtful_en_q;
    logic [15:0] doubtful_event_reg_q;
    logic [15:0] doubtful_prev_q;
    logic [15:0] run_state_en_q;
    logic [15:0] err_mem [QDEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    logic        blocked_q;
    logic [7:0]  msg_cnt_q;

    function automatic logic [7:0] code_bits(input logic signed [15:0] c);
        logic [7:0] b;
        b = 8'h00;
        if (c == isr_pkg::ERR_PARSE)
            b[isr_pkg::SE_PARSE] = 1'b1;
        if (c >= isr_pkg::ERR_RUN_LO && c <= isr_pkg::ERR_RUN_HI)
            b[isr_pkg::SE_RUN] = 1'b1;
        if (c >= isr_pkg::ERR_DEV_LO && c <= isr_pkg::ERR_DEV_HI)
            b[isr_pkg::SE_DEVICE] = 1'b1;
        if (c >= isr_pkg::ERR_QRY_LO && c <= isr_pkg::ERR_QRY_HI)
            b[isr_pkg::SE_QUERY] = 1'b1;
        return b;
    endfunction

    wire logic is_cls = req.cmd == isr_pkg::ISR_CMD_CLS;

    // ------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------
    wire logic [PW:0] used      = wr_q - rd_q;
    wire logic        q_empty   = used == '0;
    wire logic        q_full    = used == (PW+1)'(QDEPTH);
    wire logic        q_pop     = req.cmd == isr_pkg::ISR_CMD_ERR_READ && !q_empty;
    wire logic        take_push = err_push && !blocked_q && err_code != isr_pkg::ERR_NONE;
    wire logic        spill     = take_push && q_full && !q_pop;
    logic [7:0]       push_bits;

    always_comb
    begin
        push_bits = 8'h00;
        if (take_push)
            push_bits = spill ? code_bits(isr_pkg::ERR_OVERFLOW) : code_bits(err_code);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q      <= '0;
            rd_q      <= '0;
            blocked_q <= 1'b0;
        end
        else if (is_cls)
        begin
            wr_q      <= '0;
            rd_q      <= '0;
            blocked_q <= 1'b0;
        end
        else
        begin
            if (q_pop)
            begin
                rd_q      <= rd_q + 1'b1;
                blocked_q <= 1'b0;
            end
            if (spill)
            begin
                err_mem[PW'(wr_q - 1'b1)] <= isr_pkg::ERR_OVERFLOW;
                blocked_q                 <= 1'b1;
            end
            else if (take_push)
            begin
                err_mem[PW'(wr_q)] <= err_code;
                wr_q               <= wr_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Output queue occupancy
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            msg_cnt_q <= 8'h00;
        else if (new_message || is_cls)
            msg_cnt_q <= 8'h00;
        else if (msg_put && !msg_take && msg_cnt_q != 8'hff)
            msg_cnt_q <= msg_cnt_q + 8'h01;
        else if (msg_take && !msg_put && msg_cnt_q != 8'h00)
            msg_cnt_q <= msg_cnt_q - 8'h01;
    end

    // ------------------------------------------------------------
    // Standard event register
    // ------------------------------------------------------------
    logic [7:0] se_set;

    always_comb
    begin
        se_set = push_bits;
        se_set[isr_pkg::SE_ALL_DONE]  = se_set[isr_pkg::SE_ALL_DONE] | evt.all_done;
        se_set[isr_pkg::SE_QUERY]     = se_set[isr_pkg::SE_QUERY] | evt.query_protocol_fault;
        se_set[isr_pkg::SE_DEVICE]    = se_set[isr_pkg::SE_DEVICE] | evt.device_fault;
        se_set[isr_pkg::SE_RUN]       = se_set[isr_pkg::SE_RUN] | evt.run_fault;
        se_set[isr_pkg::SE_PARSE]     = se_set[isr_pkg::SE_PARSE] | evt.parse_fault;
        se_set[isr_pkg::SE_LOCAL_KEY] = se_set[isr_pkg::SE_LOCAL_KEY] | evt.local_key_event;
        se_set[1] = 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            std_event_reg_q <= isr_pkg::STD_EVENT_RESET;
        else if (req.cmd == isr_pkg::ISR_CMD_ESR_READ || is_cls)
            std_event_reg_q <= se_set; // (set wins over clear)
        else
            std_event_reg_q <= std_event_reg_q | se_set;
    end

    // ------------------------------------------------------------
    // Doubtful event register, rising-edge latch
    // ------------------------------------------------------------
    logic [15:0] doubtful_sync1_q;
    logic [15:0] doubtful_sync2_q;
    wire logic [15:0] doubtful_rise = doubtful_sync2_q & ~doubtful_prev_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            doubtful_sync1_q     <= 16'h0000;
            doubtful_sync2_q     <= 16'h0000;
            doubtful_prev_q      <= 16'h0000;
            doubtful_event_reg_q <= 16'h0000;
        end
        else
        begin
            doubtful_sync1_q <= doubtful_cond;
            doubtful_sync2_q <= doubtful_sync1_q;
            doubtful_prev_q  <= doubtful_sync2_q;
            if (is_cls)
                doubtful_event_reg_q <= doubtful_rise;
            else
                doubtful_event_reg_q <= doubtful_event_reg_q | doubtful_rise;
        end
    end

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            std_event_mask_q <= isr_pkg::MASK8_RESET;
            service_mask_q   <= isr_pkg::MASK8_RESET;
            doubtful_en_q    <= isr_pkg::MASK16_RESET;
            run_state_en_q   <= isr_pkg::MASK16_RESET;
        end
        else
        begin
            if (req.cmd == isr_pkg::ISR_CMD_ESE_WRITE)
                std_event_mask_q <= req.wdata[7:0];
            if (req.cmd == isr_pkg::ISR_CMD_SRE_WRITE)
                service_mask_q <= req.wdata[7:0];
            if (req.cmd == isr_pkg::ISR_CMD_QEN_WRITE)
                doubtful_en_q <= req.wdata;
            if (req.cmd == isr_pkg::ISR_CMD_OEN_WRITE)
                run_state_en_q <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Summary byte, built from current state
    // ------------------------------------------------------------
    logic [7:0] sb_d;

    always_comb
    begin
        sb_d = 8'h00;
        sb_d[isr_pkg::SB_QUEUE_BIT] = !q_empty;
        sb_d[isr_pkg::SB_DOUBT_BIT] = |(doubtful_event_reg_q & doubtful_en_q);
        sb_d[isr_pkg::SB_MSG_BIT]   = msg_cnt_q != 8'h00;
        sb_d[isr_pkg::SB_STD_BIT]   = |(std_event_reg_q & std_event_mask_q);
        sb_d[isr_pkg::SB_RUN_BIT]   = 1'b0;
        sb_d[isr_pkg::SB_RQS_BIT]   = |(sb_d & service_mask_q & 8'hbf);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            summary_byte         <= 8'h00;
            service_request_flag <= 1'b0;
        end
        else
        begin
            summary_byte         <= sb_d;
            service_request_flag <= sb_d[isr_pkg::SB_RQS_BIT];
        end
    end

    // ------------------------------------------------------------
    // Query answers, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rsp <= '0;
        else
        begin
            rsp.valid <= 1'b1;
            unique case (req.cmd)
                isr_pkg::ISR_CMD_STB_READ: rsp.rdata <= {8'h00, sb_d};
                isr_pkg::ISR_CMD_ESR_READ: rsp.rdata <= {8'h00, std_event_reg_q};
                isr_pkg::ISR_CMD_ESE_READ: rsp.rdata <= {8'h00, std_event_mask_q};
                isr_pkg::ISR_CMD_SRE_READ: rsp.rdata <= {8'h00, service_mask_q};
                isr_pkg::ISR_CMD_QEN_READ: rsp.rdata <= doubtful_en_q;
                isr_pkg::ISR_CMD_OEN_READ: rsp.rdata <= run_state_en_q;
                isr_pkg::ISR_CMD_ERR_READ:
                    rsp.rdata <= q_empty ? isr_pkg::ERR_NONE : err_mem[PW'(rd_q)];
                default:
                begin
                    rsp.valid <= 1'b0;
                    rsp.rdata <= 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_low_bits_zero: assert property (@(posedge clk) disable iff (!resetn)
        summary_byte[1:0] == 2'b00) else $error("summary low bits set");
    chk_queue_bit: assert property (@(posedge clk) disable iff (!resetn)
        summary_byte[isr_pkg::SB_QUEUE_BIT] == $past(!q_empty)) else $error("queue bit wrong");
    chk_std_summary: assert property (@(posedge clk) disable iff (!resetn)
        summary_byte[isr_pkg::SB_STD_BIT] == |($past(std_event_reg_q & std_event_mask_q)))
        else $error("std summary wrong");
    chk_run_summary: assert property (@(posedge clk) disable iff (!resetn)
        !summary_byte[isr_pkg::SB_RUN_BIT]) else $error("run summary active");
    chk_esr_clear: assert property (@(posedge clk) disable iff (!resetn)
        req.cmd == isr_pkg::ISR_CMD_ESR_READ && se_set == 8'h00
        |=> std_event_reg_q == 8'h00 && rsp.rdata[7:0] == $past(std_event_reg_q))
        else $error("esr read not clearing");
    chk_bit1_zero: assert property (@(posedge clk) disable iff (!resetn)
        !std_event_reg_q[1]) else $error("event bit 1 set");
    chk_rqs_mask: assert property (@(posedge clk) disable iff (!resetn)
        service_mask_q == 8'h00 |=> !service_request_flag) else $error("unmasked request");
    chk_new_msg: assert property (@(posedge clk) disable iff (!resetn)
        new_message |=> ##1 !summary_byte[isr_pkg::SB_MSG_BIT]) else $error("queue not cleared");
    chk_overflow_block: assert property (@(posedge clk) disable iff (!resetn)
        spill && !is_cls |=> blocked_q && wr_q == $past(wr_q))
        else $error("overflow not blocking");
    chk_parse_map: assert property (@(posedge clk) disable iff (!resetn)
        take_push && !q_full && err_code == isr_pkg::ERR_PARSE |=> std_event_reg_q[isr_pkg::SE_PARSE])
        else $error("parse code not mapped");

    cov_overflow: cover property (@(posedge clk) disable iff (!resetn) spill);
    cov_service: cover property (@(posedge clk) disable iff (!resetn) $rose(service_request_flag));
    cov_esr_read: cover property (@(posedge clk) disable iff (!resetn)
        req.cmd == isr_pkg::ISR_CMD_ESR_READ && std_event_reg_q != 8'h00);
endmodule

// File: dv/isr_host_model.sv
// Controller model that issues common commands and idles between them
module isr_host_model
(
    input  wire logic         clk,
    output isr_pkg::isr_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Command drive
    // ------------------------------------------------------------
    initial req = '{cmd: isr_pkg::ISR_CMD_NONE, wdata: 16'h0000};

    // One command per edge; the caller idles before the next message
    task automatic send(input isr_pkg::isr_cmd_e_t c, input logic [15:0] d);
        @(posedge clk);
        req <= '{cmd: c, wdata: d};
    endtask

    // Idle after each command so every response is fetched first
    task automatic idle();
        @(posedge clk);
        req <= '{cmd: isr_pkg::ISR_CMD_NONE, wdata: 16'h0000};
    endtask
endmodule

// File: dv/ieee488_status_reporting_tb.sv
// Self-checking bench for the status reporting core
module ieee488_status_reporting_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int QD = 4;
    localparam isr_pkg::isr_cmd_e_t ESR = isr_pkg::ISR_CMD_ESR_READ;
    logic               clk, resetn, err_push, msg_put, msg_take, new_message, srq;
    logic signed [15:0] err_code;
    logic [15:0]        doubtful_cond, m;
    logic [7:0]         summary_byte;
    isr_pkg::isr_req_t  req;
    isr_pkg::isr_rsp_t  rsp;
    isr_pkg::isr_evt_t  evt;
    int                 mismatches, check_count, k;
    logic [15:0]        expq[$];
    logic [5:0]         ev_v [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    logic [15:0]        ev_e [6] = '{16'h0001, 16'h0040, 16'h0008, 16'h0010, 16'h0020, 16'h0004};
    logic signed [15:0] cd [4] = '{-16'sd100, -16'sd221, -16'sd300, -16'sd420};
    logic [15:0]        cb [4] = '{16'h0020, 16'h0010, 16'h0008, 16'h0004};

    isr_host_model host (.clk(clk), .req(req));

    isr_status #(.QDEPTH(QD)) DUT (
        .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .evt(evt),
        .err_push(err_push), .err_code(err_code), .doubtful_cond(doubtful_cond),
        .msg_put(msg_put), .msg_take(msg_take), .new_message(new_message),
        .summary_byte(summary_byte), .service_request_flag(srq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Settle past the edge before looking at registered outputs
    task automatic sbchk(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        check(seen, exp);
    endtask

    task automatic rd(input isr_pkg::isr_cmd_e_t c, input logic [15:0] exp);
        expq.push_back(exp);
        host.send(c, 16'h0000);
        host.idle();
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input isr_pkg::isr_cmd_e_t c, input logic [15:0] d);
        host.send(c, d);
        host.idle();
        repeat (3) @(posedge clk);
    endtask

    task automatic ev(input logic [5:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= '0;
    endtask

    task automatic push(input logic signed [15:0] c);
        @(posedge clk);
        err_push <= 1'b1;
        err_code <= c;
        @(posedge clk);
        err_push <= 1'b0;
    endtask

    task automatic ctl(input logic [2:0] v);
        @(posedge clk);
        {msg_put, msg_take, new_message} <= v;
        @(posedge clk);
        {msg_put, msg_take, new_message} <= 3'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, response monitor, watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
        if (rsp.valid === 1'b1)
        begin
            if (expq.size() == 0)
                check(rsp.rdata, 16'hdead);
            else
                check(rsp.rdata, expq.pop_front());
        end

    initial
    begin
        #(20000 * 8);
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {resetn, err_push, msg_put, msg_take, new_message} = 5'h00;
        err_code = 16'sh0000;
        doubtful_cond = 16'h0000;
        evt = '0;
        k = $urandom(89259);
        repeat (12) @(posedge clk);
        check(summary_byte, 16'h0000);
        resetn <= 1'b1;
        rd(ESR, 16'h0080);
        rd(ESR, 16'h0000);
        rd(isr_pkg::ISR_CMD_ESE_READ, 16'h0000);
        rd(isr_pkg::ISR_CMD_SRE_READ, 16'h0000);
        rd(isr_pkg::ISR_CMD_STB_READ, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            ev(ev_v[i]);
            rd(ESR, ev_e[i]);
        end
        m = 16'($urandom_range(255)) | 16'h0020;
        wr(isr_pkg::ISR_CMD_ESE_WRITE, m);
        rd(isr_pkg::ISR_CMD_ESE_READ, m);
        wr(isr_pkg::ISR_CMD_SRE_WRITE, 16'h0020);
        ev(6'h02);
        repeat (3) @(posedge clk);
        sbchk(summary_byte, 16'h0060);
        check(srq, 16'h0001);
        rd(isr_pkg::ISR_CMD_STB_READ, 16'h0060);
        rd(ESR, 16'h0020);
        sbchk(summary_byte, 16'h0000);
        m = 16'h0000;
        for (int i = 0; i < QD; i++)
        begin
            k = $urandom_range(3);
            expq.push_back(cd[k]);
            m = m | cb[k];
            push(cd[k]);
        end
        repeat (3) @(posedge clk);
        sbchk(summary_byte[2], 16'h0001);
        for (int i = 0; i < QD; i++)
        begin
            host.send(isr_pkg::ISR_CMD_ERR_READ, 16'h0000);
            host.idle();
            repeat (2) @(posedge clk);
        end
        rd(ESR, m);
        sbchk(summary_byte[2], 16'h0000);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'h0000);
        foreach (cd[i])
            push(cd[i]);
        push(-16'sd300);
        push(-16'sd310);
        repeat (3) @(posedge clk);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'hff9c);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'hff23);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'hfed4);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'hfea2);
        rd(isr_pkg::ISR_CMD_ERR_READ, 16'h0000);
        rd(ESR, 16'h003c);
        wr(isr_pkg::ISR_CMD_QEN_WRITE, 16'h0001);
        rd(isr_pkg::ISR_CMD_QEN_READ, 16'h0001);
        doubtful_cond <= 16'h0002;
        repeat (6) @(posedge clk);
        sbchk(summary_byte[3], 16'h0000);
        @(posedge clk);
        doubtful_cond <= 16'h0003;
        repeat (6) @(posedge clk);
        sbchk(summary_byte[3], 16'h0001);
        @(posedge clk);
        doubtful_cond <= 16'h0000;
        repeat (6) @(posedge clk);
        sbchk(summary_byte[3], 16'h0001);
        wr(isr_pkg::ISR_CMD_CLS, 16'h0000);
        sbchk(summary_byte[3], 16'h0000);
        ctl(3'h4);
        sbchk(summary_byte[4], 16'h0001);
        ctl(3'h1);
        sbchk(summary_byte[4], 16'h0000);
        ctl(3'h4);
        ctl(3'h2);
        sbchk(summary_byte[4], 16'h0000);
        m = 16'($urandom());
        wr(isr_pkg::ISR_CMD_OEN_WRITE, m);
        rd(isr_pkg::ISR_CMD_OEN_READ, m);
        sbchk(summary_byte & 8'h83, 16'h0000);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(ESR, 16'h0080);
        rd(isr_pkg::ISR_CMD_SRE_READ, 16'h0000);
        report_and_stop();
    end
endmodule
